// >>> phsc_params.svh
// Constants of the phone system control register bank: offsets, fields, timing.
// Assumes a 125 MHz reference clock; included only by the register bank module, not by the other design files.
`ifndef PHSC_PARAMS_SVH
`define PHSC_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices; byte address is four times the index
// ----------------------------------------------------------------
`define PHSC_IDX_LINE_CTRL 8'h22
`define PHSC_IDX_RTC_CTRL 8'h24
`define PHSC_IDX_PIN_SHARE 8'h28
`define PHSC_IDX_LCD_CTRL 8'h2d

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PHSC_BIT_LINE_HOLD_EN 7
`define PHSC_BIT_RTC_RUN_EN 5
`define PHSC_BIT_RTC_TIMEOUT 7
`define PHSC_BIT_FRAME_SEL 0
`define PHSC_BIT_DUTY_BIAS 1
`define PHSC_BIT_BATT_EN 2
`define PHSC_BIT_BATT_LOW 4
`define PHSC_BIT_CONTRAST_LO 5
`define PHSC_BIT_CONTRAST_HI 6
`define PHSC_BIT_DISPLAY_ON 7
`define PHSC_BIT_SHARE_E 5
`define PHSC_BIT_SHARE_D_LO 6
`define PHSC_BIT_SHARE_D_HI 7

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define PHSC_RST_BYTE 8'h00
`define PHSC_CLK_KHZ 125000
`define PHSC_RTC_PERIOD_MS 1000
`define PHSC_RTC_CYCLES (`PHSC_RTC_PERIOD_MS * `PHSC_CLK_KHZ)
`define PHSC_FRAME_FAST_HZ 128
`define PHSC_FRAME_CYCLES ((`PHSC_CLK_KHZ * 1000) / `PHSC_FRAME_FAST_HZ)
`define PHSC_RTC_VECTOR 8'h14

`endif

// >>> phsc_pkg.sv
// Types of the phone system control register bank.
// Assumes phsc_params.svh supplies the numeric constants.
package phsc_pkg;

   // Power modes, Gray coded along Normal, Green, Sleep, Idle
   typedef enum logic [1:0] {
      PHSC_MODE_NORMAL = 2'h0,
      PHSC_MODE_GREEN = 2'h1,
      PHSC_MODE_SLEEP = 2'h3,
      PHSC_MODE_IDLE = 2'h2
   } phsc_mode_e;

   typedef struct packed {
      logic display_on;
      logic contrast_sel_hi;
      logic contrast_sel_lo;
      logic duty_bias_sel;
      logic frame_sel;
   } phsc_lcd_cfg_s;

   typedef struct packed {
      logic seg_port_d_high_share;
      logic seg_port_d_low_share;
      logic seg_port_e_share;
   } phsc_pin_share_s;

   typedef logic [3:0] phsc_sel_t;

endpackage

// >>> phsc_tick_gen.sv
// Periodic one-cycle tick generator.
// Assumes one synchronous reset; the count restarts whenever the enable drops.
`timescale 1ns/100ps
module phsc_tick_gen #(
   parameter int PERIOD = 1000
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_enable,
   output logic o_tick
);

   localparam int CW = (PERIOD > 1) ? $clog2(PERIOD) : 1;
   localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

   logic [CW-1:0] count_r;
   logic [CW-1:0] count_nxt;
   logic wrap;
   logic tick_r;

   assign wrap = (count_r == LAST);
   assign count_nxt = !i_enable ? '0 : (wrap ? '0 : count_r + CW'(1));
   assign o_tick = tick_r;

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         count_r <= '0;
         tick_r <= 1'b0;
      end else begin
         count_r <= count_nxt;
         tick_r <= i_enable & wrap;
      end
   end

endmodule

// >>> phsc_regs.sv
// Phone system control register bank: line control, RTC, battery detect, LCD setup.
// Assumes an AHB-Lite master on one 125 MHz clock and inputs synchronous to it.
`timescale 1ns/100ps
`include "phsc_params.svh"

module phsc_regs
   import phsc_pkg::*;
#(
   parameter int RTC_CYCLES = `PHSC_RTC_CYCLES,
   parameter int FRAME_CYCLES = `PHSC_FRAME_CYCLES
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // AHB-Lite slave
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic [31:0] o_hrdata,
   // Chip context
   input wire logic [1:0] i_op_mode,
   input wire logic i_porta_wake,
   input wire logic i_rtc_irq_ack,
   input wire logic i_batt_sense_in,
   // Line and RTC
   output logic o_line_make_out,
   output logic o_rtc_irq_request,
   output logic o_rtc_timeout_flag,
   // Battery detector and LCD
   output logic o_batt_detect_enable,
   output phsc_lcd_cfg_s o_lcd_cfg,
   output logic o_com_lo_enable,
   output logic o_lcd_frame_tick,
   output logic o_lcd_frame_phase,
   output phsc_pin_share_s o_pin_share
);

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   function automatic phsc_sel_t decode_addr(input logic [31:0] addr);
      phsc_sel_t sel;
      logic legal;
      sel = '0;
      legal = (addr[31:10] == 22'h000000) && (addr[1:0] == 2'h0);
      if (legal) begin
         sel[0] = (addr[9:2] == `PHSC_IDX_LINE_CTRL);
         sel[1] = (addr[9:2] == `PHSC_IDX_RTC_CTRL);
         sel[2] = (addr[9:2] == `PHSC_IDX_PIN_SHARE);
         sel[3] = (addr[9:2] == `PHSC_IDX_LCD_CTRL);
      end
      return sel;
   endfunction

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic addr_phase;
   phsc_sel_t addr_sel;
   logic wr_pend_r;
   phsc_sel_t wr_sel_r;
   logic [7:0] wr_byte;
   logic wr_line;
   logic wr_rtc;
   logic wr_share;
   logic wr_lcd;
   logic [31:0] rd_word;
   logic [31:0] hrdata_r;
   logic hreadyout_r;
   logic hresp_r;

   phsc_mode_e mode;
   logic line_hold_enable_r;
   logic line_hold_enable_nxt;
   logic line_make_r;
   logic line_make_nxt;
   logic line_trigger;

   logic rtc_run_enable_r;
   logic rtc_run_enable_nxt;
   logic rtc_timeout_flag_r;
   logic rtc_timeout_flag_nxt;
   logic rtc_irq_request_r;
   logic rtc_irq_request_nxt;
   logic rtc_tick;

   logic batt_detect_enable_r;
   logic batt_detect_enable_nxt;
   logic batt_low_flag_r;
   logic batt_low_flag_nxt;

   phsc_lcd_cfg_s lcd_cfg_r;
   phsc_lcd_cfg_s lcd_cfg_nxt;
   logic com_lo_enable_r;
   logic fast_tick;
   logic half_r;
   logic half_nxt;
   logic frame_tick_r;
   logic frame_tick_nxt;
   logic frame_phase_r;

   phsc_pin_share_s pin_share_r;
   phsc_pin_share_s pin_share_nxt;

   // ----------------------------------------------------------------
   // Bus slave: zero wait states, always OKAY
   // ----------------------------------------------------------------
   assign addr_phase = i_hsel & i_htrans[1] & i_hready;
   assign addr_sel = decode_addr(i_haddr);

   // Narrow writes land on the low byte lane only
   assign wr_byte = i_hwdata[7:0];
   assign wr_line = wr_pend_r & wr_sel_r[0];
   assign wr_rtc = wr_pend_r & wr_sel_r[1];
   assign wr_share = wr_pend_r & wr_sel_r[2];
   assign wr_lcd = wr_pend_r & wr_sel_r[3];

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         wr_pend_r <= 1'b0;
         wr_sel_r <= '0;
      end else if (i_hready) begin
         wr_pend_r <= addr_phase & i_hwrite;
         wr_sel_r <= addr_sel;
      end
   end

   // ----------------------------------------------------------------
   // Line control
   // ----------------------------------------------------------------
   assign mode = phsc_mode_e'(i_op_mode);

   assign line_hold_enable_nxt = wr_line ? wr_byte[`PHSC_BIT_LINE_HOLD_EN]
                                         : line_hold_enable_r;

   always_comb begin
      line_trigger = 1'b0;
      unique case (mode)
         PHSC_MODE_NORMAL: line_trigger = rtc_tick;
         PHSC_MODE_GREEN: line_trigger = rtc_tick;
         PHSC_MODE_SLEEP: line_trigger = rtc_tick | i_porta_wake;
         PHSC_MODE_IDLE: line_trigger = i_porta_wake;
      endcase
   end

   // Clearing the enable wins over a trigger in the same cycle
   assign line_make_nxt = !line_hold_enable_nxt ? 1'b0
                        : ((line_hold_enable_r & line_trigger) | line_make_r);

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         line_hold_enable_r <= 1'b0;
         line_make_r <= 1'b0;
      end else begin
         line_hold_enable_r <= line_hold_enable_nxt;
         line_make_r <= line_make_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Real-time clock
   // ----------------------------------------------------------------
   assign rtc_run_enable_nxt = wr_rtc ? wr_byte[`PHSC_BIT_RTC_RUN_EN]
                                      : rtc_run_enable_r;

   phsc_tick_gen #(
      .PERIOD(RTC_CYCLES)
   ) u_rtc_tick (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_enable(rtc_run_enable_r),
      .o_tick(rtc_tick)
   );

   // A fresh time-out always sets, even against a clearing write
   assign rtc_timeout_flag_nxt = rtc_tick
                               | (wr_rtc ? wr_byte[`PHSC_BIT_RTC_TIMEOUT]
                                         : rtc_timeout_flag_r);

   // Request ignores the time-out flag, so a stale flag never masks it
   assign rtc_irq_request_nxt = rtc_tick | (rtc_irq_request_r & ~i_rtc_irq_ack);

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         rtc_run_enable_r <= 1'b0;
         rtc_timeout_flag_r <= 1'b0;
         rtc_irq_request_r <= 1'b0;
      end else begin
         rtc_run_enable_r <= rtc_run_enable_nxt;
         rtc_timeout_flag_r <= rtc_timeout_flag_nxt;
         rtc_irq_request_r <= rtc_irq_request_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Low battery detector
   // ----------------------------------------------------------------
   assign batt_detect_enable_nxt = wr_lcd ? wr_byte[`PHSC_BIT_BATT_EN]
                                          : batt_detect_enable_r;

   // Flag follows the comparator only while powered; no settle timer here
   assign batt_low_flag_nxt = batt_detect_enable_r & i_batt_sense_in;

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         batt_detect_enable_r <= 1'b0;
         batt_low_flag_r <= 1'b0;
      end else begin
         batt_detect_enable_r <= batt_detect_enable_nxt;
         batt_low_flag_r <= batt_low_flag_nxt;
      end
   end

   // ----------------------------------------------------------------
   // LCD configuration and pin sharing
   // ----------------------------------------------------------------
   always_comb begin
      lcd_cfg_nxt = lcd_cfg_r;
      if (wr_lcd) begin
         lcd_cfg_nxt.frame_sel = wr_byte[`PHSC_BIT_FRAME_SEL];
         lcd_cfg_nxt.duty_bias_sel = wr_byte[`PHSC_BIT_DUTY_BIAS];
         lcd_cfg_nxt.contrast_sel_lo = wr_byte[`PHSC_BIT_CONTRAST_LO];
         lcd_cfg_nxt.contrast_sel_hi = wr_byte[`PHSC_BIT_CONTRAST_HI];
         lcd_cfg_nxt.display_on = wr_byte[`PHSC_BIT_DISPLAY_ON];
      end
   end

   always_comb begin
      pin_share_nxt = pin_share_r;
      if (wr_share) begin
         pin_share_nxt.seg_port_e_share = wr_byte[`PHSC_BIT_SHARE_E];
         pin_share_nxt.seg_port_d_low_share = wr_byte[`PHSC_BIT_SHARE_D_LO];
         pin_share_nxt.seg_port_d_high_share = wr_byte[`PHSC_BIT_SHARE_D_HI];
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         lcd_cfg_r <= '0;
         pin_share_r <= '0;
         com_lo_enable_r <= 1'b1;
      end else begin
         lcd_cfg_r <= lcd_cfg_nxt;
         pin_share_r <= pin_share_nxt;
         com_lo_enable_r <= ~lcd_cfg_nxt.duty_bias_sel;
      end
   end

   // ----------------------------------------------------------------
   // Frame timing: 128 Hz base, halved for 64 Hz
   // ----------------------------------------------------------------
   phsc_tick_gen #(
      .PERIOD(FRAME_CYCLES)
   ) u_frame_tick (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_enable(lcd_cfg_r.display_on),
      .o_tick(fast_tick)
   );

   // Every base tick is a frame at 128 Hz, every second one at 64 Hz
   assign half_nxt = !lcd_cfg_r.display_on ? 1'b0 : (fast_tick ? ~half_r : half_r);
   assign frame_tick_nxt = fast_tick & (lcd_cfg_r.frame_sel | half_r);

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         half_r <= 1'b0;
         frame_tick_r <= 1'b0;
         frame_phase_r <= 1'b0;
      end else begin
         half_r <= half_nxt;
         frame_tick_r <= frame_tick_nxt;
         // Drive polarity flips each frame to keep the panel free of DC
         if (!lcd_cfg_r.display_on) begin
            frame_phase_r <= 1'b0;
         end else if (frame_tick_nxt) begin
            frame_phase_r <= ~frame_phase_r;
         end
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   // Next-state values let a read right after a write see the new data
   always_comb begin
      rd_word = 32'h00000000;
      unique case (1'b1)
         addr_sel[0]: begin
            rd_word[`PHSC_BIT_LINE_HOLD_EN] = line_hold_enable_nxt;
         end
         addr_sel[1]: begin
            rd_word[`PHSC_BIT_RTC_RUN_EN] = rtc_run_enable_nxt;
            rd_word[`PHSC_BIT_RTC_TIMEOUT] = rtc_timeout_flag_nxt;
         end
         addr_sel[2]: begin
            rd_word[`PHSC_BIT_SHARE_E] = pin_share_nxt.seg_port_e_share;
            rd_word[`PHSC_BIT_SHARE_D_LO] = pin_share_nxt.seg_port_d_low_share;
            rd_word[`PHSC_BIT_SHARE_D_HI] = pin_share_nxt.seg_port_d_high_share;
         end
         addr_sel[3]: begin
            rd_word[`PHSC_BIT_FRAME_SEL] = lcd_cfg_nxt.frame_sel;
            rd_word[`PHSC_BIT_DUTY_BIAS] = lcd_cfg_nxt.duty_bias_sel;
            rd_word[`PHSC_BIT_BATT_EN] = batt_detect_enable_nxt;
            rd_word[`PHSC_BIT_BATT_LOW] = batt_low_flag_nxt;
            rd_word[`PHSC_BIT_CONTRAST_LO] = lcd_cfg_nxt.contrast_sel_lo;
            rd_word[`PHSC_BIT_CONTRAST_HI] = lcd_cfg_nxt.contrast_sel_hi;
            rd_word[`PHSC_BIT_DISPLAY_ON] = lcd_cfg_nxt.display_on;
         end
         default: begin
            rd_word = 32'h00000000;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         hrdata_r <= 32'h00000000;
         hreadyout_r <= 1'b1;
         hresp_r <= 1'b0;
      end else begin
         if (addr_phase & ~i_hwrite) begin
            hrdata_r <= rd_word;
         end
         hreadyout_r <= 1'b1;
         hresp_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign o_hreadyout = hreadyout_r;
   assign o_hresp = hresp_r;
   assign o_hrdata = hrdata_r;
   assign o_line_make_out = line_make_r;
   assign o_rtc_irq_request = rtc_irq_request_r;
   assign o_rtc_timeout_flag = rtc_timeout_flag_r;
   assign o_batt_detect_enable = batt_detect_enable_r;
   assign o_lcd_cfg = lcd_cfg_r;
   assign o_com_lo_enable = com_lo_enable_r;
   assign o_lcd_frame_tick = frame_tick_r;
   assign o_lcd_frame_phase = frame_phase_r;
   assign o_pin_share = pin_share_r;

endmodule

// >>> phsc_regs_props.sv
// Concurrent checks on the ports of the phone system control register bank.
// Assumes one AHB-Lite slave with zero wait states and a single clock.
`timescale 1ns/100ps
module phsc_regs_props
   import phsc_pkg::*;
#(
   parameter int RTC_CYCLES = 20,
   parameter int FRAME_CYCLES = 8
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   input wire logic o_hreadyout,
   input wire logic o_hresp,
   input wire logic [1:0] i_op_mode,
   input wire logic i_porta_wake,
   input wire logic i_rtc_irq_ack,
   input wire logic o_line_make_out,
   input wire logic o_rtc_irq_request,
   input wire logic o_rtc_timeout_flag,
   input wire logic o_batt_detect_enable,
   input wire phsc_lcd_cfg_s o_lcd_cfg,
   input wire logic o_com_lo_enable,
   input wire phsc_pin_share_s o_pin_share
);
   // ----------------------------------------------------------------
   // Write tracking
   // ----------------------------------------------------------------
   logic wr_pend_r;
   logic [31:0] wa_r;
   logic line_en_r;
   logic rtc_en_r;
   logic req_d_r;
   logic seen_r;
   logic [31:0] gap_r;
   wire line_wr = wr_pend_r && wa_r == 32'h88;
   wire rtc_wr = wr_pend_r && wa_r == 32'h90;
   wire share_wr = wr_pend_r && wa_r == 32'ha0;
   wire lcd_wr = wr_pend_r && wa_r == 32'hb4;
   wire req_rise = o_rtc_irq_request && !req_d_r;

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         wr_pend_r <= 1'b0;
         wa_r <= 32'h0;
         line_en_r <= 1'b0;
         rtc_en_r <= 1'b0;
         req_d_r <= 1'b0;
      end else begin
         if (i_hready) begin
            wr_pend_r <= i_hsel && i_htrans[1] && i_hwrite;
            wa_r <= i_haddr;
         end
         if (line_wr) begin
            line_en_r <= i_hwdata[7];
         end
         if (rtc_wr) begin
            rtc_en_r <= i_hwdata[5];
         end
         req_d_r <= o_rtc_irq_request;
      end
   end

   // Gap between request rises; only meaningful while the clock runs
   always_ff @(posedge i_ref_clk) begin
      if (i_rst || !rtc_en_r) begin
         seen_r <= 1'b0;
         gap_r <= 32'h0;
      end else if (req_rise) begin
         seen_r <= 1'b1;
         gap_r <= 32'h0;
      end else begin
         gap_r <= gap_r + 32'h1;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_rst);

   chk_bus_okay: assert property (o_hreadyout && !o_hresp)
      else $error("bus answer not ready and okay");
   chk_line_clear: assert property (line_wr && !i_hwdata[7] |=> !o_line_make_out)
      else $error("line make not dropped by clearing write");
   chk_line_wake: assert property (line_en_r && i_porta_wake && i_op_mode[1] && !line_wr
      |=> o_line_make_out)
      else $error("port wake did not make the line");
   chk_line_hold: assert property (o_line_make_out && !line_wr |=> o_line_make_out)
      else $error("line make dropped without a write");
   chk_rtc_pair: assert property (req_rise |-> o_rtc_timeout_flag)
      else $error("request rose without the time-out flag");
   chk_rtc_period: assert property (req_rise && seen_r |-> gap_r == RTC_CYCLES - 1)
      else $error("time-out spacing wrong");
   chk_rtc_stop: assert property ((!rtc_en_r) [*3] |-> !req_rise)
      else $error("time-out while the clock is off");
   chk_req_ack: assert property (i_rtc_irq_ack && seen_r && gap_r < RTC_CYCLES - 3
      |=> !o_rtc_irq_request)
      else $error("request not cleared by service entry");
   chk_batt_en: assert property (lcd_wr |=> o_batt_detect_enable == $past(i_hwdata[2]))
      else $error("detector enable does not follow write");
   chk_lcd_cfg: assert property (lcd_wr
      |=> o_lcd_cfg == {$past(i_hwdata[7:5]), $past(i_hwdata[1:0])})
      else $error("lcd setup does not follow write");
   chk_com_lo: assert property (lcd_wr |=> o_com_lo_enable == !$past(i_hwdata[1]))
      else $error("low commons enable wrong");
   chk_pin_share: assert property (share_wr |=> o_pin_share == $past(i_hwdata[7:5]))
      else $error("pin share does not follow write");
endmodule

bind phsc_regs phsc_regs_props #(.RTC_CYCLES(RTC_CYCLES), .FRAME_CYCLES(FRAME_CYCLES)) u_props (
   .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_hsel(i_hsel), .i_haddr(i_haddr),
   .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready),
   .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_op_mode(i_op_mode),
   .i_porta_wake(i_porta_wake), .i_rtc_irq_ack(i_rtc_irq_ack),
   .o_line_make_out(o_line_make_out), .o_rtc_irq_request(o_rtc_irq_request),
   .o_rtc_timeout_flag(o_rtc_timeout_flag), .o_batt_detect_enable(o_batt_detect_enable),
   .o_lcd_cfg(o_lcd_cfg), .o_com_lo_enable(o_com_lo_enable), .o_pin_share(o_pin_share));

// >>> phsc_far_model.sv
// Far side of the bank: battery divider comparator and telephone line.
// Assumes the bench sets the sensed voltage in millivolts.
`timescale 1ns/100ps
module phsc_far_model (
   input wire logic [15:0] i_batt_mv,
   input wire logic i_line_make_out,
   output logic o_batt_sense_in,
   output logic o_line_made
);
   // ----------------------------------------------------------------
   // Comparator and line
   // ----------------------------------------------------------------
   // Exactly at threshold counts as not low
   assign o_batt_sense_in = i_batt_mv < 16'h047e;
   assign o_line_made = i_line_make_out;
endmodule

// >>> tb_phone_system_control_regs.sv
// Self-checking bench of the phone system control register bank.
// Assumes the bank answers AHB-Lite with zero wait states; short RTC and frame counts.
`timescale 1ns/100ps
module tb_phone_system_control_regs;
   import phsc_pkg::*;
   localparam int RTC = 20;
   localparam int FRM = 8;
   localparam logic [7:0] IDX [4] = '{8'h22, 8'h24, 8'h28, 8'h2d};
   localparam logic [7:0] RMSK [4] = '{8'h80, 8'h80, 8'he0, 8'he7};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] mode = 2'h0;
   logic wake = 1'b0;
   logic ack = 1'b0;
   logic [15:0] mv = 16'h0bb8;
   logic rd_ph = 1'b0;
   logic hready, hresp, req, flag, batt_en, com_lo, ftick, fphase, sense, made, line_out;
   logic [31:0] hrdata;
   phsc_lcd_cfg_s cfg;
   phsc_pin_share_s share;
   logic [7:0] exp_q [$];
   logic [7:0] r;
   int errors = 0;
   int samples_checked = 0;
   int g;

   always #4 clk = ~clk;

   phsc_regs #(.RTC_CYCLES(RTC), .FRAME_CYCLES(FRM)) u_phsc_regs (
      .i_ref_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
      .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata), .i_op_mode(mode),
      .i_porta_wake(wake), .i_rtc_irq_ack(ack), .i_batt_sense_in(sense),
      .o_line_make_out(line_out), .o_rtc_irq_request(req), .o_rtc_timeout_flag(flag),
      .o_batt_detect_enable(batt_en), .o_lcd_cfg(cfg), .o_com_lo_enable(com_lo),
      .o_lcd_frame_tick(ftick), .o_lcd_frame_phase(fphase), .o_pin_share(share));

   phsc_far_model u_phsc_far_model (.i_batt_mv(mv), .i_line_make_out(line_out),
      .o_batt_sense_in(sense), .o_line_made(made));

   // ----------------------------------------------------------------
   // Checking and bus tasks
   // ----------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", n, exp, seen);
      end
   endtask

   task automatic final_report();
      if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 50);
      if (hready !== 1'b1) begin
         chk("hready", hready, 32'h1);
         final_report();
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
                      input logic [7:0] e);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {22'h0, idx, 2'h0};
      htrans <= 2'h2;
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      if (!w) begin
         exp_q.push_back(e);
         rd_ph <= 1'b1;
      end
      wait_rdy();
      rd_ph <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d, 8'h00);
   endtask

   task automatic rd(input logic [7:0] idx, input logic [7:0] e);
      bus(1'b0, idx, 8'h00, e);
   endtask

   task automatic pulse_wake();
      wake <= 1'b1;
      cyc(1);
      wake <= 1'b0;
      cyc(2);
   endtask

   // Cycles from the call to seeing the request: period plus two after the enable write, period less two after an acknowledge
   task automatic wait_req(input int exp_n);
      int n;
      n = 0;
      while (req !== 1'b1 && n < 3 * RTC) begin
         @(posedge clk);
         n++;
      end
      chk("rtc_req", req, 32'h1);
      if (req !== 1'b1) final_report();
      chk("rtc_gap", n, exp_n);
      ack <= 1'b1;
      cyc(1);
      ack <= 1'b0;
      cyc(1);
      chk("req_ack", req, 32'h0);
      chk("flag_kept", flag, 32'h1);
   endtask

   task automatic frame_gap(output int gap);
      int n;
      n = 0;
      while (ftick !== 1'b1 && n < 64) begin
         @(posedge clk);
         n++;
      end
      @(posedge clk);
      gap = 1;
      while (ftick !== 1'b1 && gap < 64) begin
         @(posedge clk);
         gap++;
      end
   endtask

   // Read results are judged where they appear, against the oldest note
   always @(posedge clk) begin
      if (rd_ph && hready) chk("hrdata", hrdata, {24'h0, exp_q.pop_front()});
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(76520));
      cyc(8);
      rst <= 1'b0;
      for (int i = 0; i < 4; i++) rd(IDX[i], 8'h00);
      rd(8'h21, 8'h00);
      repeat (4) begin
         for (int i = 0; i < 4; i++) begin
            // Keep the clock off here; its own scenario times it
            r = 8'($urandom()) & (i == 1 ? 8'h80 : 8'hff);
            wr(IDX[i], r);
            rd(IDX[i], r & RMSK[i]);
            if (i == 2) chk("pin_share", share, r[7:5]);
            if (i == 3) chk("batt_en", batt_en, r[2]);
         end
         chk("com_lo", com_lo, 32'(!r[1]));
         chk("lcd_cfg", cfg, {r[7:5], r[1:0]});
      end
      for (int i = 0; i < 4; i++) wr(IDX[i], 8'h00);
      wr(8'h2d, 8'h04);
      cyc(6250);
      mv <= 16'h047d;
      cyc(2);
      rd(8'h2d, 8'h14);
      mv <= 16'h047e;
      cyc(2);
      rd(8'h2d, 8'h04);
      mv <= 16'h047d;
      wr(8'h2d, 8'h00);
      cyc(2);
      rd(8'h2d, 8'h00);
      for (int m = 0; m < 4; m++) begin
         mode <= 2'(m);
         pulse_wake();
         chk("line_refused", made, 32'h0);
         wr(8'h22, 8'h80);
         pulse_wake();
         chk("line_wake", made, 32'(m >= 2));
         wr(8'h22, 8'h00);
         cyc(1);
         chk("line_clear", made, 32'h0);
         wr(8'h22, 8'h80);
         wr(8'h24, 8'h20);
         wait_req(RTC + 2);
         chk("line_rtc", made, 32'(m != 2));
         wait_req(RTC - 2);
         rd(8'h24, 8'ha0);
         wr(8'h24, 8'h00);
         wr(8'h22, 8'h00);
         cyc(1);
         chk("line_end", made, 32'h0);
      end
      wr(8'h2d, 8'h81);
      frame_gap(g);
      chk("frame_fast", g, FRM);
      wr(8'h2d, 8'h80);
      frame_gap(g);
      frame_gap(g);
      chk("frame_slow", g, 2 * FRM);
      wr(8'h2d, 8'h00);
      cyc(3);
      chk("phase_off", fphase, 32'h0);
      final_report();
   end
endmodule
